/* File: design/timer_pkg.sv */
package timer_pkg;
  localparam int          CNT_W          = 16;
  localparam int          NUM_CH         = 4;
  localparam int          DT_W           = 8;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_TOP        = 12'h004;
  localparam logic [11:0] OFF_COUNT      = 12'h008;
  localparam logic [11:0] OFF_STATUS     = 12'h00C;
  localparam logic [11:0] OFF_MASK       = 12'h010;
  localparam logic [11:0] OFF_DEADTIME   = 12'h014;
  localparam logic [11:0] OFF_CH_BASE    = 12'h020;
  localparam logic [11:0] OFF_CH_STRIDE  = 12'h010;
  localparam logic [11:0] OFF_CH_CFG     = 12'h000;
  localparam logic [11:0] OFF_CH_VAL     = 12'h004;
  // Control fields
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_DTEN_BIT  = 1;
  // Channel config fields
  localparam int          CFG_MODE_LSB   = 0;
  localparam int          CFG_EDGE_LSB   = 2;
  localparam int          CFG_POL_BIT    = 4;
  // Status bits: 0 overflow, 1+ch channel event
  localparam int          ST_OVF_BIT     = 0;
  localparam logic [15:0] TOP_RESET      = 16'hFFFF;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_PWM
  } ch_mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE
  } edge_sel_t;
endpackage : timer_pkg

/* File: design/chan_if.sv */
`timescale 1ns/1ns
interface chan_if;
  logic                                  tick;
  logic [timer_pkg::CNT_W-1:0]           count;
  logic [timer_pkg::CNT_W-1:0]           top;
  timer_pkg::ch_mode_t                   mode;
  timer_pkg::edge_sel_t                  edge_sel;
  logic                                  pol;
  logic [timer_pkg::CNT_W-1:0]           thresh;
  logic                                  cap_in;
  logic                                  event_p;
  logic [timer_pkg::CNT_W-1:0]           cap_val;
  logic                                  wave;
  modport ctl (output tick, count, top, mode, edge_sel, pol, thresh,
               cap_in, input event_p, cap_val, wave);
  modport ch  (input tick, count, top, mode, edge_sel, pol, thresh,
               cap_in, output event_p, cap_val, wave);
endinterface : chan_if

/* File: design/cc_channel.sv */
`timescale 1ns/1ns
module cc_channel (
  input  wire logic pclk,
  input  wire logic presetn,
  chan_if.ch        c
);
  logic                        cap_q;
  logic                        rise;
  logic                        fall;
  logic                        hit_edge;
  logic                        match;
  logic                        next_wave;
  logic [timer_pkg::CNT_W-1:0] buf_val;
  logic                        wave_q;
  logic                        event_q;

  assign rise     = c.cap_in & ~cap_q;
  assign fall     = ~c.cap_in & cap_q;
  assign hit_edge = (c.edge_sel == timer_pkg::EDGE_RISE) ? rise :
                    (c.edge_sel == timer_pkg::EDGE_FALL) ? fall :
                    (c.edge_sel == timer_pkg::EDGE_BOTH) ? (rise | fall) :
                    1'b0;
  assign match    = c.tick & (c.count == c.thresh);

  // Compare toggles on match; PWM high while count below threshold
  always_comb begin
    next_wave = wave_q;
    unique case (c.mode)
      timer_pkg::MODE_OFF:     next_wave = 1'b0;
      timer_pkg::MODE_CAPTURE: next_wave = 1'b0;
      timer_pkg::MODE_COMPARE: next_wave = match ? ~wave_q : wave_q;
      timer_pkg::MODE_PWM:     next_wave = (c.count < c.thresh);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q   <= 1'b0;
      buf_val <= '0;
      wave_q  <= 1'b0;
      event_q <= 1'b0;
    end else begin
      cap_q   <= c.cap_in;
      wave_q  <= next_wave;
      event_q <= 1'b0;
      if (c.mode == timer_pkg::MODE_CAPTURE && hit_edge) begin
        buf_val <= c.count;
        event_q <= 1'b1;
      end else if (c.mode != timer_pkg::MODE_CAPTURE &&
                   c.mode != timer_pkg::MODE_OFF && match) begin
        event_q <= 1'b1;
      end
    end
  end

  assign c.cap_val = buf_val;
  assign c.wave    = wave_q ^ c.pol;
  assign c.event_p = event_q;
endmodule : cc_channel

/* File: design/cc_pwm_timer.sv */
`timescale 1ns/1ns
// How it works
// - Timer built on a 16-bit counter
// - Up to four channels share counter
// - Channel mode: capture, compare or PWM
// - Capture copies counter on chosen edge
// - Compare output toggles on counter-threshold match
// - PWM waveform from written compare values
// - Dead-time insertion only in unit 0
// - Events driven onto reflex network outputs
module cc_pwm_timer #(
  parameter int UNIT_ID = 0,
  parameter int N_CH    = timer_pkg::NUM_CH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_CH-1:0]   cap_in,
  output logic      [N_CH-1:0]   cc_out,
  output logic      [N_CH-1:0]   cc_out_n,
  output logic      [N_CH:0]     reflex_network,
  output logic                   irq
);
  localparam int CW = timer_pkg::CNT_W;
  localparam int SW = N_CH + 1;
  // Dead-time hardware only exists in the first unit
  localparam bit HAS_DT = (UNIT_ID == 0);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic              run;
  logic              dt_en;
  logic [CW-1:0]     top;
  logic [CW-1:0]     count;
  logic [SW-1:0]     status;
  logic [SW-1:0]     mask;
  logic [timer_pkg::DT_W-1:0] dead;
  logic [4:0]        ch_cfg [N_CH];
  logic [CW-1:0]     ch_val [N_CH];

  logic [N_CH-1:0]   ev;
  logic [CW-1:0]     cap_val [N_CH];
  logic [N_CH-1:0]   wave;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  logic              wr;
  logic              rd;
  logic              in_ch;
  logic [11:0]       ch_off;
  logic [1:0]        ch_idx;
  logic              ch_idx_ok;
  logic [11:0]       ch_sub;
  logic              mapped;
  logic [31:0]       next_prdata;

  function automatic logic [11:0] ch_addr(input int i,
                                          input logic [11:0] sub);
    ch_addr = timer_pkg::OFF_CH_BASE
            + 12'(i) * timer_pkg::OFF_CH_STRIDE + sub;
  endfunction : ch_addr

  assign wr        = psel & penable & pwrite;
  assign rd        = psel & penable & ~pwrite;
  assign in_ch     = paddr >= timer_pkg::OFF_CH_BASE;
  assign ch_off    = paddr - timer_pkg::OFF_CH_BASE;
  assign ch_idx    = ch_off[5:4];
  assign ch_idx_ok = in_ch && (ch_off < 12'(N_CH) * 12'h010);
  assign ch_sub    = {8'h00, ch_off[3:0]};
  assign mapped    = (paddr[1:0] == 2'b00) &&
                     ((paddr == timer_pkg::OFF_CTRL)     ||
                      (paddr == timer_pkg::OFF_TOP)      ||
                      (paddr == timer_pkg::OFF_COUNT)    ||
                      (paddr == timer_pkg::OFF_STATUS)   ||
                      (paddr == timer_pkg::OFF_MASK)     ||
                      (paddr == timer_pkg::OFF_DEADTIME) ||
                      (ch_idx_ok &&
                       (ch_sub == timer_pkg::OFF_CH_CFG ||
                        ch_sub == timer_pkg::OFF_CH_VAL)));

  // Zero wait states; unmapped accesses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    next_prdata = timer_pkg::ZERO_WORD;
    if (paddr == timer_pkg::OFF_CTRL)
      next_prdata = {30'h0, dt_en, run};
    else if (paddr == timer_pkg::OFF_TOP)
      next_prdata = {16'h0, top};
    else if (paddr == timer_pkg::OFF_COUNT)
      next_prdata = {16'h0, count};
    else if (paddr == timer_pkg::OFF_STATUS)
      next_prdata = 32'(status);
    else if (paddr == timer_pkg::OFF_MASK)
      next_prdata = 32'(mask);
    else if (paddr == timer_pkg::OFF_DEADTIME)
      next_prdata = 32'(dead);
    else begin
      for (int i = 0; i < N_CH; i++) begin
        if (paddr == ch_addr(i, timer_pkg::OFF_CH_CFG))
          next_prdata = 32'(ch_cfg[i]);
        else if (paddr == ch_addr(i, timer_pkg::OFF_CH_VAL))
          // Capture mode reads the captured value, else the threshold
          next_prdata = (ch_cfg[i][1:0] == 2'(timer_pkg::MODE_CAPTURE)) ?
                        {16'h0, cap_val[i]} : {16'h0, ch_val[i]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= timer_pkg::ZERO_WORD;
    else if (psel & ~penable & ~pwrite)
      prdata <= next_prdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  logic tick;
  assign tick = run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run   <= 1'b0;
      dt_en <= 1'b0;
      top   <= timer_pkg::TOP_RESET;
      mask  <= '0;
      dead  <= '0;
    end else if (wr) begin
      if (paddr == timer_pkg::OFF_CTRL) begin
        run   <= pwdata[timer_pkg::CTRL_RUN_BIT];
        dt_en <= HAS_DT & pwdata[timer_pkg::CTRL_DTEN_BIT];
      end
      if (paddr == timer_pkg::OFF_TOP)
        top <= pwdata[CW-1:0];
      if (paddr == timer_pkg::OFF_MASK)
        mask <= pwdata[SW-1:0];
      if (paddr == timer_pkg::OFF_DEADTIME && HAS_DT)
        dead <= pwdata[timer_pkg::DT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_CH; i++) begin
        ch_cfg[i] <= '0;
        ch_val[i] <= '0;
      end
    end else if (wr && ch_idx_ok) begin
      if (ch_sub == timer_pkg::OFF_CH_CFG)
        ch_cfg[ch_idx] <= pwdata[4:0];
      if (ch_sub == timer_pkg::OFF_CH_VAL)
        ch_val[ch_idx] <= pwdata[CW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter
  logic ovf;
  assign ovf = tick & (count == top);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count <= '0;
    else if (wr && paddr == timer_pkg::OFF_COUNT)
      count <= pwdata[CW-1:0];
    else if (tick)
      count <= ovf ? '0 : count + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // Channels
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : gen_ch
      chan_if ci ();
      assign ci.tick     = tick;
      assign ci.count    = count;
      assign ci.top      = top;
      assign ci.mode     = timer_pkg::ch_mode_t'(ch_cfg[g][1:0]);
      assign ci.edge_sel = timer_pkg::edge_sel_t'(ch_cfg[g][3:2]);
      assign ci.pol      = ch_cfg[g][timer_pkg::CFG_POL_BIT];
      assign ci.thresh   = ch_val[g];
      assign ci.cap_in   = cap_in[g];
      assign ev[g]       = ci.event_p;
      assign cap_val[g]  = ci.cap_val;
      assign wave[g]     = ci.wave;

      cc_channel u_ch (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (ci)
      );

      // Dead time: both sides stay off for exactly dead cycles per edge
      logic                       w_q;
      logic [timer_pkg::DT_W-1:0] dcnt;
      logic                       hi;
      logic                       lo;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          w_q  <= 1'b0;
          dcnt <= '0;
          hi   <= 1'b0;
          lo   <= 1'b0;
        end else begin
          w_q <= wave[g];
          if (!dt_en) begin
            hi <= wave[g];
            lo <= ~wave[g];
          end else if (wave[g] != w_q && dead != '0) begin
            // Break before make: the edge cycle counts as the first
            hi   <= 1'b0;
            lo   <= 1'b0;
            dcnt <= dead - 8'h01;
          end else if (dcnt != '0) begin
            dcnt <= dcnt - 8'h01;
          end else begin
            hi <= wave[g];
            lo <= ~wave[g];
          end
        end
      end
      assign cc_out[g]   = hi;
      assign cc_out_n[g] = lo;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Events, status and interrupt
  logic [SW-1:0] evs;
  logic          ovf_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovf_q <= 1'b0;
    else
      ovf_q <= ovf;
  end
  assign evs = {ev, ovf_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status <= '0;
    else if (wr && paddr == timer_pkg::OFF_STATUS)
      // A new event in the clearing cycle survives
      status <= (status & ~pwdata[SW-1:0]) | evs;
    else
      status <= status | evs;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      reflex_network <= '0;
    else
      reflex_network <= evs;
  end

  assign irq = |(status & mask);
endmodule : cc_pwm_timer

/* File: verif/cc_pwm_timer_monitor.sv */
`timescale 1ns/1ns
module cc_pwm_timer_monitor #(
  parameter int N_CH = 4
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [N_CH-1:0] cap_in,
  input wire logic [N_CH-1:0] cc_out,
  input wire logic [N_CH-1:0] cc_out_n,
  input wire logic [N_CH:0]   reflex_network,
  input wire logic            irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ovf; reflex_network[0] |=> !reflex_network[0]; endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow pulse too long");
  property p_chev;
    (reflex_network[N_CH:1] & $past(reflex_network[N_CH:1])) == '0;
  endproperty
  a_chev: assert property (p_chev)
    else $error("channel pulse too long");
  property p_gap; (cc_out & cc_out_n) == '0; endproperty
  a_gap: assert property (p_gap)
    else $error("both outputs high");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("wait state seen");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err)
    else $error("error outside access");
  property p_err_rd; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rd: assert property (p_err_rd)
    else $error("unmapped read not zero");
  property p_cnt_w;
    psel && penable && !pwrite && paddr == timer_pkg::OFF_COUNT
      |-> prdata[31:16] == 16'h0;
  endproperty
  a_cnt_w: assert property (p_cnt_w)
    else $error("count wider than 16 bits");
  property p_irq;
    $rose(irq) |-> $past(psel && penable && pwrite) || (|reflex_network);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without cause");
endmodule : cc_pwm_timer_monitor

bind cc_pwm_timer cc_pwm_timer_monitor #(.N_CH(N_CH)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .cc_out(cc_out),
  .cc_out_n(cc_out_n), .reflex_network(reflex_network), .irq(irq));

/* File: verif/pin_model.sv */
`timescale 1ns/1ns
module pin_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic       lvl,
  output logic      [3:0] cap_in
);
  // Levels change only on clock edges: inputs are synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_in <= 4'h0;
    end else if (go) begin
      cap_in[sel] <= lvl;
    end
  end
endmodule : pin_model

/* File: verif/cc_pwm_timer_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module cc_pwm_timer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        err, irq, pin_go, pin_lvl;
  logic [1:0]  pin_sel;
  logic [3:0]  cap_in, cc_out, cc_out_n, prev;
  logic [4:0]  reflex_network;
  int          fail_count, comparisons, ovf, chev, j;
  int          tog[4], hi[4], hn[4];
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  cc_pwm_timer #(.UNIT_ID(0), .N_CH(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .cc_out(cc_out),
    .cc_out_n(cc_out_n), .reflex_network(reflex_network), .irq(irq));
  pin_model u_pins (.pclk(pclk), .presetn(presetn), .go(pin_go),
    .sel(pin_sel), .lvl(pin_lvl), .cap_in(cap_in));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] cfg(input int c);
    return timer_pkg::OFF_CH_BASE + 12'(c) * timer_pkg::OFF_CH_STRIDE;
  endfunction : cfg
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rdat)
  endtask : rd
  task automatic pin(input int c, input logic l);
    @(posedge pclk);
    pin_go <= 1'b1;
    pin_sel <= 2'(c);
    pin_lvl <= l;
    @(posedge pclk);
    pin_go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pin
  // Full periods only, so counts do not depend on phase
  task automatic watch(input int n);
    ovf = 0;
    chev = 0;
    tog = '{default: 0};
    hi = '{default: 0};
    hn = '{default: 0};
    @(negedge pclk);
    prev = cc_out;
    repeat (n) begin
      @(negedge pclk);
      ovf += int'(reflex_network[0]);
      chev += int'(reflex_network[3]);
      for (j = 0; j < 4; j++) begin
        tog[j] += int'(cc_out[j] != prev[j]);
        hi[j] += int'(cc_out[j]);
        hn[j] += int'(cc_out_n[j]);
      end
      prev = cc_out;
    end
  endtask : watch
  task automatic test_done;
    $display("checks %0d failures %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, pin_go, pin_lvl, presetn} = 6'h00;
    {paddr, pwdata, pin_sel} = 46'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(timer_pkg::OFF_CTRL, 32'h0);
    rd(timer_pkg::OFF_TOP, 32'h0000_FFFF);
    rd(12'hFFC, 32'h0);
    `CHK("pslverr", 1'b1, err)
    wr(timer_pkg::OFF_TOP, 32'h9);
    wr(timer_pkg::OFF_CTRL, 32'h1);
    // First wrap plus pipeline lands late; count in steady state
    repeat (12) @(posedge pclk);
    watch(40);
    `CHK("overflows", 4, ovf)
    wr(timer_pkg::OFF_MASK, 32'h1);
    @(negedge pclk);
    `CHK("irq", 1'b1, irq)
    wr(timer_pkg::OFF_CTRL, 32'h0);
    wr(timer_pkg::OFF_STATUS, 32'h1);
    @(negedge pclk);
    `CHK("irq", 1'b0, irq)
    wr(timer_pkg::OFF_MASK, 32'h0);
    wr(timer_pkg::OFF_COUNT, 32'h0001_2345);
    rd(timer_pkg::OFF_COUNT, 32'h0000_2345);
    wr(timer_pkg::OFF_STATUS, 32'h1F);
    wr(cfg(0), 32'h1);
    pin(0, 1'b1);
    rd(cfg(0) + timer_pkg::OFF_CH_VAL, 32'h2345);
    rd(timer_pkg::OFF_STATUS, 32'h2);
    wr(cfg(1), 32'h5);
    pin(1, 1'b1);
    rd(cfg(1) + timer_pkg::OFF_CH_VAL, 32'h0);
    wr(timer_pkg::OFF_COUNT, 32'h0777);
    pin(1, 1'b0);
    rd(cfg(1) + timer_pkg::OFF_CH_VAL, 32'h0777);
    wr(cfg(2), 32'h2);
    wr(cfg(2) + timer_pkg::OFF_CH_VAL, 32'h5);
    wr(timer_pkg::OFF_COUNT, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h1);
    watch(40);
    `CHK("toggles", 4, tog[2])
    `CHK("ch2 events", 4, chev)
    wr(cfg(3), 32'h3);
    wr(cfg(3) + timer_pkg::OFF_CH_VAL, 32'h3);
    repeat (12) @(posedge pclk);
    watch(40);
    `CHK("pwm high", 12, hi[3])
    `CHK("pwm low", 28, hn[3])
    wr(cfg(3) + timer_pkg::OFF_CH_VAL, 32'h7);
    repeat (12) @(posedge pclk);
    watch(40);
    `CHK("pwm high", 28, hi[3])
    wr(timer_pkg::OFF_DEADTIME, 32'h2);
    rd(timer_pkg::OFF_DEADTIME, 32'h2);
    wr(timer_pkg::OFF_CTRL, 32'h3);
    repeat (12) @(posedge pclk);
    watch(40);
    `CHK("dead gap", 1'b1, hi[3] + hn[3] < 40)
    `CHK("dead high", 20, hi[3])
    `CHK("dead low", 4, hn[3])
    test_done;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    test_done;
  end
endmodule : cc_pwm_timer_tb
